// ---- rtl/gtu_defs.svh ----
`ifndef GTU_DEFS_SVH
`define GTU_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define GTU_TMR_W        16
`define GTU_PSC_W        10
`define GTU_PSC_SEL_W    3

// ----------------------------------------------------------------
// resolution: log2 of system clocks per count
// ----------------------------------------------------------------
`define GTU_G1_RES_LOG2  2
`define GTU_G2_RES_LOG2  1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GTU_CNT_RST      16'h0000

// ----------------------------------------------------------------
// edge and trigger select bit positions
// ----------------------------------------------------------------
`define GTU_EDGE_RISE    0
`define GTU_EDGE_FALL    1
`define GTU_TRG_PIN_RISE 0
`define GTU_TRG_PIN_FALL 1
`define GTU_TRG_TL_RISE  2
`define GTU_TRG_TL_FALL  3
`define GTU_CAP_IN_RISE  0
`define GTU_CAP_IN_FALL  1
`define GTU_CAP_CORE_IN  2
`define GTU_CAP_CORE_DIR 3

`endif

// ---- rtl/gtu_pin_dec.sv ----
`timescale 1ns/1ps
`default_nettype none

// edge and quadrature decoding for one pin pair
module gtu_pin_dec (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic a_i,
  input  wire logic b_i,
  output logic      a_rise_o,
  output logic      a_fall_o,
  output logic      b_rise_o,
  output logic      b_fall_o,
  output logic      q_step_o,
  output logic      q_up_o
);
  typedef struct packed {
    logic a;
    logic b;
  } gtu_dec_s;

  gtu_dec_s st_reg;
  gtu_dec_s st_next;

  always_comb begin
    st_next = '{a: a_i, b: b_i};
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign a_rise_o = a_i & ~st_reg.a;
  assign a_fall_o = ~a_i & st_reg.a;
  assign b_rise_o = b_i & ~st_reg.b;
  assign b_fall_o = ~b_i & st_reg.b;
  // any phase edge is one count; phase order gives direction
  assign q_step_o = (a_i ^ st_reg.a) | (b_i ^ st_reg.b);
  assign q_up_o   = st_reg.a ^ b_i;
endmodule

`default_nettype wire

// ---- rtl/gtu_pkg.sv ----
package gtu_pkg;

  // ----------------------------------------------------------------
  // first module timer modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GTU_G1_TIMER   = 3'h0,
    GTU_G1_GATE_HI = 3'h1,
    GTU_G1_GATE_LO = 3'h2,
    GTU_G1_COUNTER = 3'h3,
    GTU_G1_INCR    = 3'h4,
    GTU_G1_CONCAT  = 3'h5,
    GTU_G1_CAPTURE = 3'h6,
    GTU_G1_RELOAD  = 3'h7
  } gtu_g1_mode_e;

  // ----------------------------------------------------------------
  // second module timer modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GTU_G2_TIMER   = 2'h0,
    GTU_G2_COUNTER = 2'h1,
    GTU_G2_CONCAT  = 2'h2,
    GTU_G2_STOP    = 2'h3
  } gtu_g2_mode_e;

endpackage

// ---- rtl/gtu_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gtu_defs.svh"

// one up/down timer with its own prescaler
module gtu_timer #(
  parameter int W        = `GTU_TMR_W,
  parameter int RES_LOG2 = `GTU_G1_RES_LOG2,
  parameter int PSC_W    = `GTU_PSC_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic [`GTU_PSC_SEL_W-1:0] psc_sel_i,
  input  wire logic                      step_i,
  input  wire logic                      up_i,
  input  wire logic                      load_i,
  input  wire logic [W-1:0]              load_val_i,
  input  wire logic                      clear_i,
  output logic                           psc_tick_o,
  output logic [W-1:0]                   value_o,
  output logic                           ovf_o,
  output logic                           unf_o
);
  typedef struct packed {
    logic [PSC_W-1:0] psc;
    logic [W-1:0]     cnt;
  } gtu_tmr_s;

  gtu_tmr_s         st_reg;
  gtu_tmr_s         st_next;
  logic [PSC_W-1:0] mask;
  logic             busy;

  // tick every 2**(RES_LOG2+sel) clocks
  assign mask = PSC_W'((32'h1 << (RES_LOG2 + int'(psc_sel_i))) - 1);
  assign psc_tick_o = (st_reg.psc & mask) == mask;
  assign busy = load_i | clear_i;
  assign ovf_o = step_i & up_i & ~busy & (st_reg.cnt == '1);   // R20
  assign unf_o = step_i & ~up_i & ~busy & (st_reg.cnt == '0);  // R20
  assign value_o = st_reg.cnt;

  always_comb begin
    st_next = st_reg;
    st_next.psc = st_reg.psc + PSC_W'(1);
    if (clear_i) begin
      st_next.cnt = '0;
    end else if (load_i) begin
      st_next.cnt = load_val_i;
    end else if (step_i) begin
      // wraps naturally at both ends
      st_next.cnt = up_i ? st_reg.cnt + W'(1) : st_reg.cnt - W'(1); // R20
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

`default_nettype wire

// ---- rtl/gtu_top.sv ----
// ----------------------------------------------------------------
// Overview of operation
// [R1] five 16-bit timers in two modules
// [R2] timers run alone or chained in module
// [R3] first module: timer, gated, counter, incremental
// [R4] prescaled system clock or external pin events
// [R5] gated mode counts only while gate enables
// [R6] first module finest step four clocks
// [R7] software direction, optionally flipped by pin
// [R8] incremental mode decodes two sensor phases
// [R9] core toggle latch flips on wrap
// [R10] capture or reload aux timer stops counting
// [R11] aux capture latches core on pin event
// [R12] aux reload loads core on selected trigger
// [R13] opposite latch edges reload gives PWM
// [R14] second module finest step two clocks
// [R15] second timers prescaled or external clocked
// [R16] second toggle latch flips on wrap
// [R17] second wrap clocks array, reloads second timer from capture register
// [R18] capture register latches source timer, optional clear
// [R19] capture also from core input/direction pins
// [R20] timers wrap at ends, flagging over/underflow
// [R21] wrap and capture raise request flags
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "gtu_defs.svh"

module gtu_top (
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire gtu_pkg::gtu_g1_mode_e     aux_lo_mode_i,
  input  wire gtu_pkg::gtu_g1_mode_e     core_mode_i,
  input  wire gtu_pkg::gtu_g1_mode_e     aux_hi_mode_i,
  input  wire logic [`GTU_PSC_SEL_W-1:0] aux_lo_psc_i,
  input  wire logic [`GTU_PSC_SEL_W-1:0] core_psc_i,
  input  wire logic [`GTU_PSC_SEL_W-1:0] aux_hi_psc_i,
  input  wire logic                      aux_lo_run_i,
  input  wire logic                      core_run_i,
  input  wire logic                      aux_hi_run_i,
  input  wire logic                      aux_lo_up_i,
  input  wire logic                      core_up_i,
  input  wire logic                      aux_hi_up_i,
  input  wire logic                      aux_lo_ext_dir_en_i,
  input  wire logic                      core_ext_dir_en_i,
  input  wire logic                      aux_hi_ext_dir_en_i,
  input  wire logic [1:0]                aux_lo_edge_i,
  input  wire logic [1:0]                core_edge_i,
  input  wire logic [1:0]                aux_hi_edge_i,
  input  wire logic [3:0]                aux_lo_trig_i,
  input  wire logic [3:0]                aux_hi_trig_i,
  input  wire logic                      aux_lo_input_pin_i,
  input  wire logic                      core_input_pin_i,
  input  wire logic                      aux_hi_input_pin_i,
  input  wire logic                      aux_lo_direction_pin_i,
  input  wire logic                      core_direction_pin_i,
  input  wire logic                      aux_hi_direction_pin_i,
  input  wire logic                      core_toggle_out_en_i,
  input  wire gtu_pkg::gtu_g2_mode_e     cap_src_mode_i,
  input  wire gtu_pkg::gtu_g2_mode_e     sec_out_mode_i,
  input  wire logic [`GTU_PSC_SEL_W-1:0] cap_src_psc_i,
  input  wire logic [`GTU_PSC_SEL_W-1:0] sec_out_psc_i,
  input  wire logic                      cap_src_run_i,
  input  wire logic                      sec_out_run_i,
  input  wire logic                      cap_src_up_i,
  input  wire logic                      sec_out_up_i,
  input  wire logic                      cap_src_ext_dir_en_i,
  input  wire logic                      sec_out_ext_dir_en_i,
  input  wire logic [1:0]                cap_src_edge_i,
  input  wire logic [1:0]                sec_out_edge_i,
  input  wire logic                      cap_src_input_pin_i,
  input  wire logic                      sec_out_input_pin_i,
  input  wire logic                      cap_src_direction_pin_i,
  input  wire logic                      sec_out_direction_pin_i,
  input  wire logic                      capture_input_pin_i,
  input  wire logic [3:0]                cap_trig_i,
  input  wire logic                      cap_clear_en_i,
  input  wire logic                      cap_reload_en_i,
  input  wire logic                      sec_toggle_out_en_i,
  output logic                           core_toggle_out_pin_o,
  output logic                           second_toggle_out_pin_o,
  output logic                           capcom_clk_o,
  output logic [`GTU_TMR_W-1:0]          aux_lo_value_o,
  output logic [`GTU_TMR_W-1:0]          core_value_o,
  output logic [`GTU_TMR_W-1:0]          aux_hi_value_o,
  output logic [`GTU_TMR_W-1:0]          cap_src_value_o,
  output logic [`GTU_TMR_W-1:0]          sec_out_value_o,
  output logic [`GTU_TMR_W-1:0]          capture_reload_value_o,
  output logic [4:0]                     ovf_flag_o,
  output logic [4:0]                     unf_flag_o,
  output logic                           capture_flag_o
);
  import gtu_pkg::*;

  localparam int W = `GTU_TMR_W; // R1

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic         core_tl;
    logic         core_tgl;
    logic         sec_tl;
    logic         sec_tgl;
    logic [W-1:0] cap;
    logic [4:0]   ovf;
    logic [4:0]   unf;
    logic         cap_flag;
    logic         capcom_clk;
    logic         core_pin;
    logic         sec_pin;
  } gtu_top_s;

  gtu_top_s st_reg;
  gtu_top_s st_next;

  // ----------------------------------------------------------------
  // first module, index 0 aux low, 1 core, 2 aux high
  // ----------------------------------------------------------------
  gtu_g1_mode_e              g1_mode [3];
  logic [`GTU_PSC_SEL_W-1:0] g1_psc  [3];
  logic [1:0]                g1_edge [3];
  logic [W-1:0]              g1_val  [3];
  logic [W-1:0]              g1_ldv  [3];
  logic [2:0] g1_run, g1_upsw, g1_xdir, g1_in, g1_dpin;
  logic [2:0] a_rise, a_fall, b_rise, b_fall, q_step, q_up, ptick;
  logic [2:0] g1_step, g1_up, g1_load, g1_ovf, g1_unf;
  logic [2:0] pin_ev, rl_trig, cp_trig;
  logic       core_wrap, tl_rise, tl_fall;

  assign g1_mode = '{aux_lo_mode_i, core_mode_i, aux_hi_mode_i};
  assign g1_psc  = '{aux_lo_psc_i, core_psc_i, aux_hi_psc_i};
  assign g1_edge = '{aux_lo_edge_i, core_edge_i, aux_hi_edge_i};
  assign g1_run  = {aux_hi_run_i, core_run_i, aux_lo_run_i};
  assign g1_upsw = {aux_hi_up_i, core_up_i, aux_lo_up_i};
  assign g1_xdir = {aux_hi_ext_dir_en_i, core_ext_dir_en_i,
                    aux_lo_ext_dir_en_i};
  assign g1_in   = {aux_hi_input_pin_i, core_input_pin_i,
                    aux_lo_input_pin_i};
  assign g1_dpin = {aux_hi_direction_pin_i, core_direction_pin_i,
                    aux_lo_direction_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_g1
      gtu_pin_dec u_dec (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .a_i      (g1_in[gi]),
        .b_i      (g1_dpin[gi]),
        .a_rise_o (a_rise[gi]),
        .a_fall_o (a_fall[gi]),
        .b_rise_o (b_rise[gi]),
        .b_fall_o (b_fall[gi]),
        .q_step_o (q_step[gi]),
        .q_up_o   (q_up[gi])
      );
      gtu_timer #(
        .W        (W),
        .RES_LOG2 (`GTU_G1_RES_LOG2)
      ) u_tmr (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .psc_sel_i  (g1_psc[gi]),
        .step_i     (g1_step[gi]),
        .up_i       (g1_up[gi]),
        .load_i     (g1_load[gi]),
        .load_val_i (g1_ldv[gi]),
        .clear_i    (1'b0),
        .psc_tick_o (ptick[gi]),
        .value_o    (g1_val[gi]),
        .ovf_o      (g1_ovf[gi]),
        .unf_o      (g1_unf[gi])
      );

      // selected count or capture edge on the input pin
      assign pin_ev[gi] =
        (g1_edge[gi][`GTU_EDGE_RISE] & a_rise[gi]) |
        (g1_edge[gi][`GTU_EDGE_FALL] & a_fall[gi]);

      // incremental mode direction comes from the phases
      assign g1_up[gi] = (g1_mode[gi] == GTU_G1_INCR) ? q_up[gi] :  // R8
                         g1_upsw[gi] ^ (g1_xdir[gi] & g1_dpin[gi]); // R7

      always_comb begin
        case (g1_mode[gi])
          GTU_G1_TIMER:   g1_step[gi] = ptick[gi]; // R4 R6
          GTU_G1_GATE_HI: g1_step[gi] = ptick[gi] & g1_in[gi]; // R5
          GTU_G1_GATE_LO: g1_step[gi] = ptick[gi] & ~g1_in[gi]; // R5
          GTU_G1_COUNTER: g1_step[gi] = pin_ev[gi]; // R4
          GTU_G1_INCR:    g1_step[gi] = q_step[gi]; // R8
          GTU_G1_CONCAT:  g1_step[gi] = (gi != 1) & st_reg.core_tgl; // R2
          default:        g1_step[gi] = 1'b0; // R10
        endcase
        g1_step[gi] = g1_step[gi] & g1_run[gi]; // R3
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // core toggle latch, capture and reload
  // ----------------------------------------------------------------
  // raw wrap, independent of a reload, so no loop through the load
  assign core_wrap = g1_step[1] &
    (g1_up[1] ? (g1_val[1] == '1) : (g1_val[1] == '0)); // R9
  assign tl_rise   = core_wrap & ~st_reg.core_tl;
  assign tl_fall   = core_wrap & st_reg.core_tl;

  always_comb begin
    for (int i = 0; i < 3; i += 2) begin
      logic [3:0] ts;
      ts = (i == 0) ? aux_lo_trig_i : aux_hi_trig_i;
      cp_trig[i] = (g1_mode[i] == GTU_G1_CAPTURE) & pin_ev[i]; // R11
      rl_trig[i] = (g1_mode[i] == GTU_G1_RELOAD) & // R12
                   ((ts[`GTU_TRG_PIN_RISE] & a_rise[i]) |
                    (ts[`GTU_TRG_PIN_FALL] & a_fall[i]) |
                    (ts[`GTU_TRG_TL_RISE] & tl_rise) | // R13
                    (ts[`GTU_TRG_TL_FALL] & tl_fall));
    end
    cp_trig[1] = 1'b0;
    rl_trig[1] = rl_trig[0] | rl_trig[2];
    g1_load    = {cp_trig[2], rl_trig[1], cp_trig[0]};
    g1_ldv[0]  = g1_val[1]; // R11
    g1_ldv[2]  = g1_val[1]; // R11
    g1_ldv[1]  = rl_trig[0] ? g1_val[0] : g1_val[2]; // R12
  end

  // ----------------------------------------------------------------
  // second module
  // ----------------------------------------------------------------
  logic [W-1:0] t5_val;
  logic [W-1:0] t6_val;
  logic         t5_tick, t6_tick, t5_step, t6_step;
  logic         t5_ovf, t5_unf, t6_ovf, t6_unf;
  logic         t5_rise, t5_fall, t6_rise, t6_fall, ci_rise, ci_fall;
  logic         t6_wrap, cap_ev, t5_clr, t6_load;

  gtu_pin_dec u_dec5 (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .a_i      (cap_src_input_pin_i),
    .b_i      (capture_input_pin_i),
    .a_rise_o (t5_rise),
    .a_fall_o (t5_fall),
    .b_rise_o (ci_rise),
    .b_fall_o (ci_fall),
    .q_step_o (),
    .q_up_o   ()
  );

  gtu_pin_dec u_dec6 (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .a_i      (sec_out_input_pin_i),
    .b_i      (sec_out_direction_pin_i),
    .a_rise_o (t6_rise),
    .a_fall_o (t6_fall),
    .b_rise_o (),
    .b_fall_o (),
    .q_step_o (),
    .q_up_o   ()
  );

  always_comb begin
    case (cap_src_mode_i)
      GTU_G2_TIMER:   t5_step = t5_tick; // R15
      GTU_G2_COUNTER: t5_step =
        (cap_src_edge_i[`GTU_EDGE_RISE] & t5_rise) |
        (cap_src_edge_i[`GTU_EDGE_FALL] & t5_fall); // R15
      GTU_G2_CONCAT:  t5_step = st_reg.sec_tgl; // R16
      default:        t5_step = 1'b0;
    endcase
    t5_step = t5_step & cap_src_run_i;
    case (sec_out_mode_i)
      GTU_G2_TIMER:   t6_step = t6_tick; // R14
      GTU_G2_COUNTER: t6_step =
        (sec_out_edge_i[`GTU_EDGE_RISE] & t6_rise) |
        (sec_out_edge_i[`GTU_EDGE_FALL] & t6_fall); // R15
      default:        t6_step = 1'b0;
    endcase
    t6_step = t6_step & sec_out_run_i;
  end

  // capture trigger from its own pin or the core pins
  assign cap_ev =
    (cap_trig_i[`GTU_CAP_IN_RISE] & ci_rise) | // R18
    (cap_trig_i[`GTU_CAP_IN_FALL] & ci_fall) | // R18
    (cap_trig_i[`GTU_CAP_CORE_IN] & (a_rise[1] | a_fall[1])) | // R19
    (cap_trig_i[`GTU_CAP_CORE_DIR] & (b_rise[1] | b_fall[1])); // R19
  assign t5_clr  = cap_ev & cap_clear_en_i; // R18
  assign t6_wrap = t6_ovf | t6_unf;
  assign t6_load = t6_wrap & cap_reload_en_i; // R17

  gtu_timer #(
    .W        (W),
    .RES_LOG2 (`GTU_G2_RES_LOG2)
  ) u_t5 (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .psc_sel_i  (cap_src_psc_i),
    .step_i     (t5_step),
    .up_i       (cap_src_up_i ^
                 (cap_src_ext_dir_en_i & cap_src_direction_pin_i)),
    .load_i     (1'b0),
    .load_val_i (`GTU_CNT_RST),
    .clear_i    (t5_clr),
    .psc_tick_o (t5_tick),
    .value_o    (t5_val),
    .ovf_o      (t5_ovf),
    .unf_o      (t5_unf)
  );

  gtu_timer #(
    .W        (W),
    .RES_LOG2 (`GTU_G2_RES_LOG2)
  ) u_t6 (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .psc_sel_i  (sec_out_psc_i),
    .step_i     (t6_step),
    .up_i       (sec_out_up_i ^
                 (sec_out_ext_dir_en_i & sec_out_direction_pin_i)),
    .load_i     (t6_load),
    .load_val_i (st_reg.cap),
    .clear_i    (1'b0),
    .psc_tick_o (t6_tick),
    .value_o    (t6_val),
    .ovf_o      (t6_ovf),
    .unf_o      (t6_unf)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next            = st_reg;
    st_next.core_tl    = st_reg.core_tl ^ core_wrap; // R9
    st_next.core_tgl   = core_wrap; // R9
    st_next.sec_tl     = st_reg.sec_tl ^ t6_wrap; // R16
    st_next.sec_tgl    = t6_wrap; // R16
    st_next.capcom_clk = t6_wrap; // R17
    if (cap_ev) begin
      st_next.cap = t5_val; // R18
    end
    st_next.ovf = {t6_ovf, t5_ovf, g1_ovf[2], g1_ovf[1], g1_ovf[0]}; // R21
    st_next.unf = {t6_unf, t5_unf, g1_unf[2], g1_unf[1], g1_unf[0]}; // R21
    st_next.cap_flag   = cap_ev; // R21
    st_next.core_pin   = core_toggle_out_en_i & st_next.core_tl; // R9
    st_next.sec_pin    = sec_toggle_out_en_i & st_next.sec_tl; // R16
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign core_toggle_out_pin_o   = st_reg.core_pin;
  assign second_toggle_out_pin_o = st_reg.sec_pin;
  assign capcom_clk_o            = st_reg.capcom_clk;
  assign aux_lo_value_o          = g1_val[0];
  assign core_value_o            = g1_val[1];
  assign aux_hi_value_o          = g1_val[2];
  assign cap_src_value_o         = t5_val;
  assign sec_out_value_o         = t6_val;
  assign capture_reload_value_o  = st_reg.cap;
  assign ovf_flag_o              = st_reg.ovf;
  assign unf_flag_o              = st_reg.unf;
  assign capture_flag_o          = st_reg.cap_flag;
endmodule

`default_nettype wire

// ---- tb/gtu_quad_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-phase position sensor: one phase step every GAP clocks while go_i
module gtu_quad_model #(
  parameter int GAP = 6
) (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic fwd_i,
  output logic      a_o,
  output logic      b_o
);
  int         cnt = 0;
  logic [1:0] ph  = 2'h0;
  always @(posedge clk_i) begin
    cnt <= (go_i && cnt != GAP - 1) ? cnt + 1 : 0;
    if (go_i && cnt == GAP - 1)
      ph <= fwd_i ? ph + 2'h1 : ph - 2'h1;
  end
  assign a_o = ph[1];
  assign b_o = ph[1] ^ ph[0];
endmodule
`default_nettype wire

// ---- tb/gtu_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module gtu_sva (
  input wire logic                  clk_i,
  input wire logic                  resetn_i,
  input wire gtu_pkg::gtu_g1_mode_e core_mode_i,
  input wire gtu_pkg::gtu_g1_mode_e aux_lo_mode_i,
  input wire gtu_pkg::gtu_g1_mode_e aux_hi_mode_i,
  input wire gtu_pkg::gtu_g2_mode_e sec_out_mode_i,
  input wire logic                  cap_reload_en_i,
  input wire logic                  core_toggle_out_en_i,
  input wire logic                  core_toggle_out_pin_o,
  input wire logic                  capcom_clk_o,
  input wire logic [15:0]           core_value_o,
  input wire logic [15:0]           sec_out_value_o,
  input wire logic [15:0]           aux_lo_value_o,
  input wire logic [15:0]           cap_src_value_o,
  input wire logic [15:0]           capture_reload_value_o,
  input wire logic [4:0]            ovf_flag_o,
  input wire logic [4:0]            unf_flag_o,
  input wire logic                  capture_flag_o
);
  import gtu_pkg::*;
  // ----------------------------------------------------------------
  // wrap, rate and capture checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_core_up;
    core_value_o == 16'hFFFF ##1 core_value_o == 16'h0000;
  endsequence
  sequence s_sec_dn;
    sec_out_value_o == 16'h0000 ##1 sec_out_value_o == 16'hFFFF;
  endsequence
  chk_core_ovf_flag: assert property (s_core_up |-> ##[0:1] ovf_flag_o[1])
    else $error("core wrap without overflow flag");
  chk_sec_unf_flag: assert property (s_sec_dn |-> ##[0:1] unf_flag_o[4])
    else $error("second timer wrap without underflow flag");
  chk_toggle_on_wrap: assert property (ovf_flag_o[1] && core_toggle_out_en_i
    && $past(core_toggle_out_en_i, 2) |-> $changed(core_toggle_out_pin_o))
    else $error("core toggle pin did not flip");
  chk_capcom_clk: assert property (ovf_flag_o[4] || unf_flag_o[4]
    |-> capcom_clk_o) else $error("no array clock on wrap");
  chk_g1_step_rate: assert property ($changed(core_value_o)
    && core_mode_i == GTU_G1_TIMER && aux_lo_mode_i != GTU_G1_RELOAD
    && aux_hi_mode_i != GTU_G1_RELOAD |=> $stable(core_value_o) [*3])
    else $error("core stepped faster than four clocks");
  chk_g2_step_rate: assert property ($changed(sec_out_value_o)
    && sec_out_mode_i == GTU_G2_TIMER && !cap_reload_en_i
    |=> $stable(sec_out_value_o)) else $error("second timer too fast");
  chk_cap_latch_value: assert property (capture_flag_o |->
    capture_reload_value_o == $past(cap_src_value_o)
    || capture_reload_value_o == $past(cap_src_value_o, 2))
    else $error("capture register holds wrong value");
  chk_aux_stopped: assert property ((aux_lo_mode_i == GTU_G1_RELOAD) [*2]
    |-> $stable(aux_lo_value_o)) else $error("reload aux timer counted");
endmodule
bind gtu_top gtu_sva chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gtu_pkg::*;
  logic clk_i = 0, resetn_i = 0, q_go = 0, q_fwd = 1;
  gtu_g1_mode_e aux_lo_mode_i = GTU_G1_TIMER, core_mode_i = GTU_G1_TIMER;
  gtu_g1_mode_e aux_hi_mode_i = GTU_G1_TIMER;
  gtu_g2_mode_e cap_src_mode_i = GTU_G2_STOP, sec_out_mode_i = GTU_G2_STOP;
  logic [2:0] aux_lo_psc_i = 0, core_psc_i = 0, aux_hi_psc_i = 0;
  logic [2:0] cap_src_psc_i = 0, sec_out_psc_i = 0;
  logic [1:0] aux_lo_edge_i = 0, core_edge_i = 0, aux_hi_edge_i = 0;
  logic [1:0] cap_src_edge_i = 0, sec_out_edge_i = 0;
  logic [3:0] aux_lo_trig_i = 0, aux_hi_trig_i = 0, cap_trig_i = 0;
  logic aux_lo_run_i = 0, core_run_i = 0, aux_hi_run_i = 0, aux_lo_up_i = 0;
  logic core_up_i = 0, aux_hi_up_i = 0, aux_lo_ext_dir_en_i = 0;
  logic core_ext_dir_en_i = 0, aux_hi_ext_dir_en_i = 0;
  logic aux_lo_input_pin_i = 0, aux_hi_input_pin_i = 0;
  logic aux_lo_direction_pin_i = 0, aux_hi_direction_pin_i = 0;
  logic core_toggle_out_en_i = 0, cap_src_run_i = 0, sec_out_run_i = 0;
  logic cap_src_up_i = 0, sec_out_up_i = 0, cap_src_ext_dir_en_i = 0;
  logic sec_out_ext_dir_en_i = 0, cap_src_input_pin_i = 0;
  logic sec_out_input_pin_i = 0, cap_src_direction_pin_i = 0;
  logic sec_out_direction_pin_i = 0, capture_input_pin_i = 0;
  logic cap_clear_en_i = 0, cap_reload_en_i = 0, sec_toggle_out_en_i = 0;
  wire logic core_input_pin_i, core_direction_pin_i;
  logic core_toggle_out_pin_o, second_toggle_out_pin_o, capcom_clk_o;
  logic capture_flag_o;
  logic [15:0] aux_lo_value_o, core_value_o, aux_hi_value_o, v;
  logic [15:0] cap_src_value_o, sec_out_value_o, capture_reload_value_o;
  logic [4:0] ovf_flag_o, unf_flag_o;
  int mismatches = 0, tests_run = 0, cycles = 0, ncap = 0;
  gtu_top dut (.*);
  gtu_quad_model qm (.clk_i, .go_i(q_go), .fwd_i(q_fwd),
    .a_o(core_input_pin_i), .b_o(core_direction_pin_i));
  // ----------------------------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------------------------
  always #2.5 clk_i = ~clk_i;
  always @(negedge clk_i) if (capture_flag_o === 1'b1) ncap++;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic p);
    p = 1;
    cyc(3);
    p = 0;
    cyc(3);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    resetn_i = 1;
    core_run_i = 1;
    core_up_i = 1;
    for (int s = 0; s < 2; s++) begin
      core_psc_i = 3'(s);
      for (int k = 0; k < 2; k++) begin
        v = core_value_o;
        for (int i = 0; i < 40 && core_value_o === v; i++) cyc(1);
      end
      v = core_value_o;
      cyc(80);
      chk(core_value_o, v + 16'(80 >> (2 + s)));
    end
    core_run_i = 0;
    sec_out_mode_i = GTU_G2_TIMER;
    sec_toggle_out_en_i = 1;
    sec_out_run_i = 1;
    for (int i = 0; i < 40 && unf_flag_o[4] !== 1'b1; i++) cyc(1);
    chk(16'(capcom_clk_o), 16'h0001);
    chk(16'(second_toggle_out_pin_o), 16'h0001);
    v = sec_out_value_o;
    cyc(40);
    chk(sec_out_value_o, v - 16'h0014);
    sec_out_run_i = 0;
    aux_lo_run_i = 1;
    for (int i = 0; i < 40 && unf_flag_o[0] !== 1'b1; i++) cyc(1);
    aux_lo_run_i = 0;
    chk(aux_lo_value_o, 16'hFFFF);
    aux_lo_mode_i = GTU_G1_RELOAD;
    aux_lo_trig_i = 4'h1;
    pulse(aux_lo_input_pin_i);
    chk(core_value_o, 16'hFFFF);
    aux_hi_mode_i = GTU_G1_CAPTURE;
    aux_hi_edge_i = 2'h1;
    pulse(aux_hi_input_pin_i);
    chk(aux_hi_value_o, 16'hFFFF);
    aux_lo_trig_i = 4'h0;
    core_toggle_out_en_i = 1;
    cyc(2);
    core_run_i = 1;
    for (int i = 0; i < 40 && ovf_flag_o[1] !== 1'b1; i++) cyc(1);
    chk(core_value_o, 16'h0000);
    chk(16'(core_toggle_out_pin_o), 16'h0001);
    core_run_i = 0;
    chk(aux_lo_value_o, 16'hFFFF);
    core_mode_i = GTU_G1_INCR;
    cap_trig_i = 4'hC;
    cyc(4);
    core_run_i = 1;
    v = core_value_o;
    for (int d = 1; d >= 0; d--) begin
      q_fwd = d[0];
      q_go = 1;
      cyc(48);
      q_go = 0;
      cyc(6);
      chk(core_value_o, d ? v + 16'h0008 : v);
    end
    chk(16'(ncap), 16'h0010);
    cap_trig_i = 4'h1;
    cap_src_mode_i = GTU_G2_COUNTER;
    cap_src_edge_i = 2'h1;
    cap_src_run_i = 1;
    cap_src_up_i = 1;
    repeat (3) pulse(cap_src_input_pin_i);
    chk(cap_src_value_o, 16'h0003);
    cap_clear_en_i = 1;
    pulse(capture_input_pin_i);
    chk(capture_reload_value_o, 16'h0003);
    chk(cap_src_value_o, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
